/* File: sadc_core_model.sv */
/* Behavioural analog core for the sequencer bench.
   Assumes the bench holds code and dly steady during a conversion. */
`timescale 1ns/1ps
`default_nettype none
module sadc_core_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        conv_start,
  input  wire logic        core_power,
  input  wire logic [11:0] code,
  input  wire logic [3:0]  dly,
  output logic             core_done,
  output logic [11:0]      core_code
);
  logic [3:0]  cnt;
  logic        run;
  logic [11:0] last;
  // Inverse outside done, so a late latch reads garbage
  assign core_code = core_done ? last : ~last;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {run, core_done, cnt, last} <= '0;
    end else begin
      core_done <= 1'b0;
      if (!core_power) begin
        run <= 1'b0;
      end else if (conv_start) begin
        run <= 1'b1;
        cnt <= dly;
      end else if (run && cnt == 4'h0) begin
        run       <= 1'b0;
        core_done <= 1'b1;
        last      <= code;
      end else if (run) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sadc_justify.v */
/*
  Result formatter: builds the high and low result bytes.
  Assumes a 12-bit code from the converter core, two's complement
  when differential.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.vh"
module sadc_justify (
  input  wire [11:0] code,
  input  wire        diff,
  input  wire        left_justify_select,
  output reg  [15:0] word
);
  always @* begin
    if (left_justify_select)
      word = {code, `SADC_NIBBLE};
    else if (diff)
      word = {{4{code[11]}}, code};
    else
      word = {`SADC_NIBBLE, code};
  end
endmodule
`default_nettype wire

/* File: sadc_regs.vh */
/*
  Constants for the converter sequencer: start sources, gain codes,
  justification fields and sample timing.
  Assumes inclusion by bare name from sadc design files.
*/
`ifndef SADC_REGS_VH
`define SADC_REGS_VH
`define SADC_SRC_SOFT      2'h0
`define SADC_SRC_TMR2      2'h1
`define SADC_SRC_TMR3      2'h2
`define SADC_SRC_EXT       2'h3
`define SADC_CHAN_TEMP     4'h8
`define SADC_CHAN_LAST     4'h8
`define SADC_GAIN_HALF     3'h6
`define SADC_GAIN_LAST     3'h4
`define SADC_CLK_MHZ       100
`define SADC_RATE_KSPS     100
`define SADC_PERIOD_CYC    ((`SADC_CLK_MHZ * 1000) / `SADC_RATE_KSPS)
`define SADC_TRACK_CYC     30
`define SADC_BITS          12
`define SADC_NIBBLE        4'h0
`endif

/* File: sadc_seq.v */
/*
  Sequencer around the successive-approximation converter core:
  channel, gain, reference select, start sources, result latch,
  window compare and shutdown.
  Assumes timers and start pin synchronous to sys_clk, and an analog
  core that answers conv_start with core_done and core_code.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.vh"
module sadc_seq #(
  parameter PERIOD_CYC = `SADC_PERIOD_CYC,
  parameter TRACK_CYC  = `SADC_TRACK_CYC
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        enable,
  input  wire [1:0]  start_select,
  input  wire        soft_start,
  input  wire        timer2_overflow,
  input  wire        timer3_overflow,
  input  wire        ext_start,
  input  wire        background_mode,
  input  wire        int_enable,
  input  wire        window_int_enable,
  input  wire        window_outside,
  input  wire [15:0] window_upper,
  input  wire [15:0] window_lower,
  input  wire [3:0]  input_channel_select,
  input  wire [3:0]  pair_differential,
  input  wire [2:0]  gain_select,
  input  wire        left_justify_select,
  input  wire        ref_select_dac,
  input  wire        clear_done,
  input  wire        clear_window,
  input  wire        core_done,
  input  wire [11:0] core_code,
  output reg         core_power,
  output reg         conv_start,
  output reg         track,
  output reg  [3:0]  mux_pos,
  output reg  [3:0]  mux_neg,
  output reg         mux_diff,
  output reg  [2:0]  amp_gain,
  output reg         ref_dac,
  output reg  [7:0]  result_high_byte,
  output reg  [7:0]  result_low_byte,
  output reg         done_flag,
  output reg         window_flag,
  output wire        irq,
  output wire        window_irq,
  output reg         busy
);
  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_TRACK = 2'h1;
  localparam ST_CONV  = 2'h2;
  localparam ST_HOLD  = 2'h3;


  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  reg  [1:0]  state;
  reg  [15:0] cnt;
  reg         ext_prev;
  reg         conv_diff;
  wire [15:0] word;
  wire        trig;
  wire        hit;
  wire        in_win;

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------
  // Pair of a channel: even/odd external inputs share one differential bit
  function is_diff;
    input [3:0] ch;
    input [3:0] pairs;
    begin
      is_diff = (ch < `SADC_CHAN_TEMP) && pairs[ch[2:1]];
    end
  endfunction

  // ----------------------------------------------------------------
  // Start source
  // ----------------------------------------------------------------
  // Background mode restarts from the period counter instead
  assign trig = (start_select == `SADC_SRC_SOFT) ? soft_start :
                (start_select == `SADC_SRC_TMR2) ? timer2_overflow :
                (start_select == `SADC_SRC_TMR3) ? timer3_overflow :
                (ext_start & ~ext_prev);

  // ----------------------------------------------------------------
  // Window compare
  // ----------------------------------------------------------------
  // Compare signed when differential so negative codes order right
  // Limits are in the justified format, so software must program
  // them to match left_justify_select
  assign in_win = conv_diff ?
    (($signed(word) <= $signed(window_upper)) &&
     ($signed(word) >= $signed(window_lower))) :
    ((word <= window_upper) && (word >= window_lower));
  assign hit = in_win ^ window_outside;

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  // Background mode keeps the processor quiet unless the window hits
  assign irq        = done_flag & int_enable & ~background_mode;
  assign window_irq = window_flag & window_int_enable;

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  sadc_justify sadc_justify_i (
    .code                (core_code),
    .diff                (conv_diff),
    .left_justify_select (left_justify_select),
    .word                (word)
  );

  // ----------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mux_pos    <= 4'h0;
      mux_neg    <= 4'h0;
      mux_diff   <= 1'b0;
      amp_gain   <= 3'h0;
      ref_dac    <= 1'b0;
      core_power <= 1'b0;
      ext_prev   <= 1'b0;
    end else begin
      ext_prev   <= ext_start;
      core_power <= enable;
      ref_dac    <= ref_select_dac;
      amp_gain   <= (gain_select > `SADC_GAIN_LAST &&
                     gain_select != `SADC_GAIN_HALF) ?
                    3'h0 : gain_select;
      if (state == ST_IDLE) begin
        // Clamp out-of-range channel to the first input
        mux_pos  <= (input_channel_select > `SADC_CHAN_LAST) ?
                    4'h0 : input_channel_select;
        mux_diff <= is_diff(input_channel_select, pair_differential);
        mux_neg  <= {input_channel_select[3:1], 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state            <= ST_IDLE;
      cnt              <= 16'h0000;
      conv_start       <= 1'b0;
      track            <= 1'b0;
      busy             <= 1'b0;
      conv_diff        <= 1'b0;
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
      done_flag        <= 1'b0;
      window_flag      <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (clear_done)
        done_flag <= 1'b0;
      if (clear_window)
        window_flag <= 1'b0;
      if (cnt != 16'h0000)
        cnt <= cnt - 16'h0001;
      case (state)
        ST_IDLE: begin
          // Triggers arriving while busy are dropped, not queued,
          // so a late source cannot stretch the sample period
          track <= 1'b0;
          busy  <= 1'b0;
          if (enable && (background_mode || trig)) begin
            state     <= ST_TRACK;
            busy      <= 1'b1;
            track     <= 1'b1;
            conv_diff <= mux_diff;
            cnt       <= TRACK_CYC[15:0];
          end
        end
        ST_TRACK: begin
          if (cnt == 16'h0001) begin
            track      <= 1'b0;
            conv_start <= 1'b1;
            state      <= ST_CONV;
            cnt        <= PERIOD_CYC[15:0] - TRACK_CYC[15:0];
          end
        end
        ST_CONV: begin
          if (core_done) begin
            result_high_byte <= word[15:8];
            result_low_byte  <= word[7:0];
            done_flag        <= 1'b1;
            if (hit)
              window_flag <= 1'b1;
            state <= background_mode ? ST_HOLD : ST_IDLE;
          end else if (!enable) begin
            state <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          // Holds the sample rate in background mode
          if (cnt == 16'h0000 || !enable)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: sadc_seq_props.sv */
/* Port checker for sadc_seq.
   Assumes a bind that hands on TRACK_CYC. */
`timescale 1ns/1ps
`default_nettype none
module sadc_seq_props #(
  parameter int TRACK_CYC = 30
) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       int_enable,
  input wire logic       background_mode,
  input wire logic       window_int_enable,
  input wire logic       clear_done,
  input wire logic       left_justify_select,
  input wire logic       core_power,
  input wire logic       conv_start,
  input wire logic       track,
  input wire logic       mux_diff,
  input wire logic [2:0] amp_gain,
  input wire logic [7:0] result_high_byte,
  input wire logic [7:0] result_low_byte,
  input wire logic       done_flag,
  input wire logic       window_flag,
  input wire logic       irq,
  input wire logic       window_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_IRQ: assert property (irq == (done_flag && int_enable &&
    !background_mode)) else $error("irq gating wrong");
  AST_WIRQ: assert property (window_irq ==
    (window_flag && window_int_enable)) else $error("window irq wrong");
  AST_HOLD: assert property (done_flag && !clear_done |=> done_flag)
    else $error("done flag dropped");
  AST_TRACK: assert property ($rose(track) |-> ##TRACK_CYC
    (conv_start && !track)) else $error("track span wrong");
  AST_LEFT: assert property ($rose(done_flag) && left_justify_select
    |-> result_low_byte[3:0] == 4'h0) else $error("left pad wrong");
  AST_SE: assert property ($rose(done_flag) && !mux_diff &&
    !left_justify_select |-> result_high_byte[7:4] == 4'h0)
    else $error("single-ended nibble wrong");
  AST_SIGN: assert property ($rose(done_flag) && mux_diff &&
    !left_justify_select |-> result_high_byte[7:4] ==
    {4{result_high_byte[3]}}) else $error("sign extension wrong");
  AST_SHUT: assert property (!core_power |-> !conv_start)
    else $error("start in shutdown");
  AST_GAIN: assert property (amp_gain != 3'h5 && amp_gain != 3'h7)
    else $error("illegal gain code");
endmodule
`default_nettype wire

/* File: sadc_seq_tb.sv */
/* Self-checking bench for sadc_seq.
   Assumes small TRACK_CYC and PERIOD_CYC to keep the run short. */
`timescale 1ns/1ps
`default_nettype none
module sadc_seq_tb;
  logic sys_clk, rst, enable, soft_start, timer2_overflow, timer3_overflow;
  logic ext_start, background_mode, int_enable, window_int_enable, track;
  logic window_outside, left_justify_select, ref_select_dac, clear_done;
  logic clear_window, core_done, core_power, conv_start, mux_diff, busy;
  logic ref_dac, done_flag, window_flag, irq, window_irq;
  logic [1:0]  start_select;
  logic [2:0]  gain_select, amp_gain;
  logic [3:0]  input_channel_select, pair_differential, mux_pos, mux_neg, dly;
  logic [7:0]  result_high_byte, result_low_byte;
  logic [11:0] core_code, code;
  logic [15:0] window_upper, window_lower;
  int          err_count, checks;
  sadc_seq #(.PERIOD_CYC(20), .TRACK_CYC(4)) sadc_seq_i (.*);
  sadc_core_model sadc_core_model_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic pulse(input logic [1:0] src, input logic [11:0] c);
    @(posedge sys_clk);
    start_select <= src;
    code <= c;
    @(posedge sys_clk);
    soft_start <= 1'b1;
    {timer3_overflow, timer2_overflow} <= {src == 2'h2, src == 2'h1};
    ext_start <= src == 2'h3;
    @(posedge sys_clk);
    {soft_start, timer2_overflow, timer3_overflow, ext_start} <= 4'h0;
  endtask
  task automatic conv(input logic [1:0] src, input logic [11:0] c,
                      input logic [15:0] exp, input logic win = 1'b0);
    pulse(src, c);
    repeat (40) begin
      @(negedge sys_clk);
      if (done_flag === 1'b1) break;
    end
    chk("word", {result_high_byte, result_low_byte}, exp);
    chk("irq", irq, int_enable);
    chk("win", window_flag, win);
    @(posedge sys_clk);
    {clear_done, clear_window} <= 2'h3;
    @(posedge sys_clk);
    {clear_done, clear_window} <= 2'h0;
  endtask
  initial begin
    {enable, start_select, soft_start, timer2_overflow, timer3_overflow,
     ext_start, background_mode, int_enable, window_int_enable,
     window_outside, window_upper, window_lower, input_channel_select,
     pair_differential, gain_select, left_justify_select, ref_select_dac,
     clear_done, clear_window, code, err_count, checks} = '0;
    dly = 4'h3;
    rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    enable <= 1'b1;
    int_enable <= 1'b1;
    conv(2'h0, 12'hfff, 16'h0fff);
    conv(2'h1, 12'h800, 16'h0800);
    conv(2'h2, 12'h001, 16'h0001);
    conv(2'h3, 12'habc, 16'h0abc);
    left_justify_select <= 1'b1;
    conv(2'h0, 12'hfff, 16'hfff0);
    {pair_differential, left_justify_select} <= 5'h02;
    conv(2'h0, 12'h7ff, 16'h07ff);
    conv(2'h0, 12'hc00, 16'hfc00);
    chk("neg", {mux_diff, mux_neg}, 16'h0011);
    left_justify_select <= 1'b1;
    conv(2'h0, 12'hc00, 16'hc000);
    {pair_differential, left_justify_select} <= 5'h00;
    {input_channel_select, gain_select, ref_select_dac} <= 8'h8d;
    conv(2'h0, 12'h000, 16'h0000, 1'b1);
    chk("mux", mux_pos, 16'h0008);
    chk("gain", {ref_dac, amp_gain}, 16'h000e);
    start_select <= 2'h2;
    @(posedge sys_clk);
    {soft_start, timer2_overflow, ext_start} <= 3'h7;
    @(posedge sys_clk);
    {soft_start, timer2_overflow, ext_start} <= 3'h0;
    repeat (2) @(negedge sys_clk);
    chk("busy", busy, 16'h0);
    @(posedge sys_clk);
    enable <= 1'b0;
    pulse(2'h0, 12'h0);
    @(negedge sys_clk);
    chk("off", {core_power, busy}, 16'h0);
    {enable, window_int_enable} <= 2'h3;
    {window_upper, window_lower} <= {16'h0200, 16'h0100};
    pulse(2'h0, 12'h150);
    repeat (20) @(negedge sys_clk);
    chk("inside", window_irq, 16'h1);
    @(posedge sys_clk);
    {clear_done, clear_window} <= 2'h3;
    @(posedge sys_clk);
    {clear_done, clear_window} <= 2'h0;
    conv(2'h0, 12'h300, 16'h0300);
    window_outside <= 1'b1;
    conv(2'h0, 12'h300, 16'h0300, 1'b1);
    @(negedge sys_clk);
    chk("cleared", window_flag, 16'h0);
    @(posedge sys_clk);
    {window_outside, background_mode} <= 2'h1;
    code <= 12'h150;
    repeat (60) @(negedge sys_clk);
    chk("bg", {done_flag, irq, window_flag}, 16'h5);
    finish_test();
  end
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule
bind sadc_seq sadc_seq_props #(.TRACK_CYC(TRACK_CYC)) sadc_seq_props_i (.*);
`default_nettype wire
